// File: cpu_wake_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_wake_model (
  input  wire logic                           core_clk,
  output logic                                sleep_exec,
  output logic                                cpu_int_mask,
  output logic [power_mode_pkg::NUM_WAKE-1:0] wake_src_pins
);
  import power_mode_pkg::*;
  initial begin
    sleep_exec    = 1'b0;
    cpu_int_mask  = 1'b0;
    wake_src_pins = '0;
  end
  ////////////////////////////////////////////////////////////
  // len above one repeats the instruction while already halted
  task automatic sleep_instr(input int len);
    @(posedge core_clk);
    sleep_exec <= 1'b1;
    repeat (len) @(posedge core_clk);
    sleep_exec <= 1'b0;
  endtask
  // levels held far beyond two clocks, so capture never depends on phase
  task automatic set_pins(input logic [NUM_WAKE-1:0] v);
    @(posedge core_clk);
    wake_src_pins <= v;
  endtask
  task automatic set_mask(input logic m);
    @(posedge core_clk);
    cpu_int_mask <= m;
  endtask
endmodule // cpu_wake_model
`default_nettype wire

// File: power_mode_ctrl.sv
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module power_mode_ctrl (
  input  wire logic                                    core_clk,
  input  wire logic                                    sys_rst,
  input  wire power_mode_pkg::av_req_s                 bus_req,
  output logic      [31:0]                             readdata,
  output logic                                         waitrequest,
  input  wire logic                                    sleep_exec,
  input  wire logic                                    cpu_int_mask,
  input  wire logic [power_mode_pkg::NUM_WAKE-1:0]     wake_src_pins,
  input  wire logic                                    chip_reset_pin_n,
  output power_mode_pkg::mode_e                        mode_state,
  output logic                                         cpu_halt,
  output logic                                         int_exc_start,
  output logic                                         cpu_reset_hold,
  output logic      [7:0]                              cpu_clk_div,
  output logic                                         cpu_clk_from_watch
);
  import power_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [NUM_WAKE:0]   pins_sync;
  logic [NUM_WAKE-1:0] wake_sync_v;
  logic                pin_rst;
  logic                rst_all;

  // pins reach logic only after two flops
  wake_sync #(
    .WIDTH (NUM_WAKE + 1)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({chip_reset_pin_n, wake_src_pins}),
    .sync_out (pins_sync)
  );

  // sync flops clear to 0, so the pin reads as asserted until it settles
  assign wake_sync_v = pins_sync[NUM_WAKE-1:0];
  assign pin_rst     = ~pins_sync[NUM_WAKE];
  assign rst_all     = sys_rst | pin_rst;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]          ctrl_one_reg, ctrl_one_next;
  logic [7:0]          ctrl_two_reg, ctrl_two_next;
  logic                twatch_reg, twatch_next;
  logic [NUM_WAKE-1:0] int_en_reg, int_en_next;
  logic                wait_reg, wait_next;
  logic [31:0]         rdata_reg, rdata_next;
  logic [31:0]         rd_mux;
  logic [7:0]          wd;
  logic                wr_commit;
  mode_e               mode_reg, mode_next;

  assign wd        = bus_req.writedata[7:0];
  assign wr_commit = ~wait_reg & bus_req.write & bus_req.byteenable[0];

  always_comb begin
    case (bus_req.address)
      CTRL_ONE_OFS:    rd_mux = {24'h000000, ctrl_one_reg};
      CTRL_TWO_OFS:    rd_mux = {24'h000000, ctrl_two_reg};
      TIMER_WATCH_OFS: rd_mux = {31'h00000000, twatch_reg};
      INT_ENABLE_OFS:  rd_mux = {{(32-NUM_WAKE){1'b0}}, int_en_reg};
      MODE_STATUS_OFS: rd_mux = {24'h000000, mode_reg};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // one wait cycle, then the answer; write lands on the accepting edge
  always_comb begin
    wait_next     = 1'b1;
    rdata_next    = rdata_reg;
    ctrl_one_next = ctrl_one_reg;
    ctrl_two_next = ctrl_two_reg;
    twatch_next   = twatch_reg;
    int_en_next   = int_en_reg;
    if (wait_reg && (bus_req.read || bus_req.write)) begin
      wait_next  = 1'b0;
      rdata_next = bus_req.read ? rd_mux : 32'h00000000;
    end
    if (wr_commit) begin
      case (bus_req.address)
        CTRL_ONE_OFS: begin
          ctrl_one_next = (wd & ~CTRL_ONE_FIXED) | CTRL_ONE_FIXED;
        end
        CTRL_TWO_OFS: begin
          ctrl_two_next = (wd & ~CTRL_TWO_FIXED) | CTRL_TWO_FIXED;
          if (mode_reg == SUBACTIVE) begin
            ctrl_two_next[SA_LSB+:2] = ctrl_two_reg[SA_LSB+:2];
          end
        end
        TIMER_WATCH_OFS: begin
          twatch_next = wd[TWATCH_POS];
        end
        INT_ENABLE_OFS: begin
          int_en_next = bus_req.writedata[NUM_WAKE-1:0];
        end
        default: begin
          ctrl_one_next = ctrl_one_reg;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      ctrl_one_reg <= CTRL_ONE_RST;
      ctrl_two_reg <= CTRL_TWO_RST;
      twatch_reg   <= 1'b0;
      int_en_reg   <= INT_ENABLE_RST;
      wait_reg     <= 1'b1;
      rdata_reg    <= 32'h00000000;
    end else begin
      ctrl_one_reg <= ctrl_one_next;
      ctrl_two_reg <= ctrl_two_next;
      twatch_reg   <= twatch_next;
      int_en_reg   <= int_en_next;
      wait_reg     <= wait_next;
      rdata_reg    <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic       standby_select, low_speed_flag, direct_transfer_flag, medium_speed_flag, wake;
  logic [1:0] mdiv, sasel;
  logic       halt_next, exc_next, watch_src_next;
  logic [7:0] div_next;
  logic       halt_reg, exc_reg, rsth_reg, watch_src_reg;
  logic [7:0] div_reg;

  // control bits are taken as they stand when the sleep completes
  assign standby_select  = ctrl_one_reg[STBY_POS];
  assign low_speed_flag  = ctrl_one_reg[LOW_SPEED_FLAG_POS];
  assign direct_transfer_flag  = ctrl_two_reg[DIRECT_TRANSFER_FLAG_POS];
  assign medium_speed_flag  = ctrl_two_reg[MEDIUM_SPEED_FLAG_POS];
  // dividers follow the value being written, so a write beside a mode change never lags
  assign mdiv  = ctrl_one_next[MDIV_LSB+:2];
  assign sasel = ctrl_two_next[SA_LSB+:2];
  // masked or disabled requests never wake
  assign wake  = (|(wake_sync_v & int_en_reg)) & ~cpu_int_mask;

  always_comb begin
    mode_next = mode_reg;
    exc_next  = 1'b0;
    case (mode_reg)
      ACT_HIGH, ACT_MED: begin
        if (sleep_exec) begin
          if (direct_transfer_flag && !standby_select && medium_speed_flag && !low_speed_flag && mode_reg == ACT_HIGH) begin
            mode_next = ACT_MED;
          end else if (direct_transfer_flag && !standby_select && !medium_speed_flag && !low_speed_flag && mode_reg == ACT_MED) begin
            mode_next = ACT_HIGH;
          end else if (direct_transfer_flag && standby_select && twatch_reg && low_speed_flag) begin
            mode_next = SUBACTIVE;
          end else if (standby_select) begin
            if (twatch_reg) begin
              mode_next = WATCH;
            end else if (!low_speed_flag) begin
              mode_next = STANDBY;
            end
          end else if (!direct_transfer_flag && !low_speed_flag) begin
            // medium entry may be seen half a state early; no timing relies on it
            mode_next = medium_speed_flag ? SLEEP_MED : SLEEP_HIGH;
          end
        end
      end
      SUBACTIVE: begin
        if (sleep_exec) begin
          if (direct_transfer_flag && standby_select && twatch_reg && !low_speed_flag) begin
            mode_next = medium_speed_flag ? ACT_MED : ACT_HIGH;
          end else begin
            mode_next = standby_select ? WATCH : SUBSLEEP;
          end
        end
      end
      SLEEP_HIGH: begin
        if (wake) begin
          mode_next = ACT_HIGH;
          exc_next  = 1'b1;
        end
      end
      SLEEP_MED: begin
        if (wake) begin
          mode_next = ACT_MED;
          exc_next  = 1'b1;
        end
      end
      STANDBY: begin
        if (wake) begin
          mode_next = medium_speed_flag ? ACT_MED : ACT_HIGH;
          exc_next  = 1'b1;
        end
      end
      WATCH: begin
        if (wake) begin
          mode_next = low_speed_flag ? SUBACTIVE : (medium_speed_flag ? ACT_MED : ACT_HIGH);
          exc_next  = 1'b1;
        end
      end
      SUBSLEEP: begin
        if (wake) begin
          mode_next = SUBACTIVE;
          exc_next  = 1'b1;
        end
      end
      default: begin
        mode_next = ACT_HIGH;
      end
    endcase
  end

  // outputs follow the next mode so they stay aligned with mode_state
  always_comb begin
    halt_next      = ~(mode_next == ACT_HIGH || mode_next == ACT_MED || mode_next == SUBACTIVE);
    watch_src_next = (mode_next == SUBACTIVE || mode_next == SUBSLEEP);
    case (mode_next)
      ACT_HIGH, SLEEP_HIGH: div_next = DIV_1;
      ACT_MED, SLEEP_MED: begin
        case (mdiv)
          2'b00:   div_next = DIV_16;
          2'b01:   div_next = DIV_32;
          2'b10:   div_next = DIV_64;
          default: div_next = DIV_128;
        endcase
      end
      SUBACTIVE, SUBSLEEP: begin
        if (sasel[1]) begin
          div_next = DIV_2;
        end else begin
          div_next = sasel[0] ? DIV_4 : DIV_8;
        end
      end
      default: div_next = DIV_NONE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      mode_reg      <= ACT_HIGH;
      halt_reg      <= 1'b0;
      exc_reg       <= 1'b0;
      rsth_reg      <= 1'b1;
      watch_src_reg <= 1'b0;
      div_reg       <= DIV_1;
    end else begin
      mode_reg      <= mode_next;
      halt_reg      <= halt_next;
      exc_reg       <= exc_next;
      rsth_reg      <= 1'b0;
      watch_src_reg <= watch_src_next;
      div_reg       <= div_next;
    end
  end

  assign readdata           = rdata_reg;
  assign waitrequest        = wait_reg;
  assign mode_state         = mode_reg;
  assign cpu_halt           = halt_reg;
  assign int_exc_start      = exc_reg;
  assign cpu_reset_hold     = rsth_reg;
  assign cpu_clk_div        = div_reg;
  assign cpu_clk_from_watch = watch_src_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst_all);

  logic dir_ok;
  assign dir_ok = sleep_exec && direct_transfer_flag && !standby_select && !low_speed_flag;

  a_direct_high_med: assert property (
    dir_ok && mode_reg == ACT_HIGH && medium_speed_flag |=> mode_reg == ACT_MED && !cpu_halt)
    else $error("direct high to medium missed");
  a_direct_med_high: assert property (
    dir_ok && mode_reg == ACT_MED && !medium_speed_flag |=> mode_reg == ACT_HIGH && cpu_clk_div == DIV_1)
    else $error("direct medium to high missed");
  a_direct_to_sub: assert property (
    sleep_exec && direct_transfer_flag && standby_select && twatch_reg && low_speed_flag
      && (mode_reg == ACT_HIGH || mode_reg == ACT_MED) |=> mode_reg == SUBACTIVE)
    else $error("direct to subactive missed");
  a_sub_to_active: assert property (
    sleep_exec && mode_reg == SUBACTIVE && direct_transfer_flag && standby_select && twatch_reg && !low_speed_flag
      |=> mode_reg == ($past(medium_speed_flag) ? ACT_MED : ACT_HIGH))
    else $error("subactive direct exit wrong");
  a_sleep_high_in: assert property (
    sleep_exec && mode_reg == ACT_HIGH && !standby_select && !low_speed_flag && !medium_speed_flag && !direct_transfer_flag
      |=> mode_reg == SLEEP_HIGH && cpu_halt)
    else $error("sleep high entry missed");
  a_sleep_med_in: assert property (
    sleep_exec && mode_reg == ACT_HIGH && !standby_select && !low_speed_flag && medium_speed_flag && !direct_transfer_flag
      |=> mode_reg == SLEEP_MED && cpu_halt && cpu_clk_div != DIV_1)
    else $error("sleep medium entry missed");
  a_wake_same_speed: assert property (
    mode_reg == SLEEP_MED && wake |=> mode_reg == ACT_MED && int_exc_start ##1 !int_exc_start)
    else $error("sleep wake return wrong");
  a_masked_stays: assert property (
    mode_reg == SLEEP_HIGH && cpu_int_mask |=> mode_reg == SLEEP_HIGH)
    else $error("masked interrupt woke sleep");
  a_wake_latency: assert property (
    mode_reg == SLEEP_HIGH && wake_src_pins[0] && int_en_reg[0] && !cpu_int_mask
      ##1 (wake_src_pins[0] && !cpu_int_mask) [*2] |-> ##1 mode_reg == ACT_HIGH)
    else $error("wake latency above two clocks");
  a_sa_locked: assert property (
    mode_reg == SUBACTIVE && wr_commit && bus_req.address == CTRL_TWO_OFS
      |=> $stable(ctrl_two_reg[SA_LSB+:2]))
    else $error("subactive select changed in subactive");
  a_sub_clk_rate: assert property (
    mode_reg == SUBACTIVE |-> cpu_clk_div == (sasel[1] ? DIV_2 : (sasel[0] ? DIV_4 : DIV_8)))
    else $error("subactive divider wrong");
  a_pin_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    pin_rst |=> cpu_reset_hold && mode_state == ACT_HIGH)
    else $error("reset pin did not reset cpu");
  a_disabled_stays: assert property (
    mode_reg == SLEEP_MED && !(|(wake_sync_v & int_en_reg)) |=> mode_reg == SLEEP_MED)
    else $error("disabled interrupt woke sleep");
  a_standby_wake: assert property (
    mode_reg == STANDBY && wake |=> int_exc_start
      && mode_reg == ($past(medium_speed_flag) ? ACT_MED : ACT_HIGH))
    else $error("standby wake mode wrong");
  a_watch_wake: assert property (
    mode_reg == WATCH && wake && !low_speed_flag |=> int_exc_start
      && mode_reg == ($past(medium_speed_flag) ? ACT_MED : ACT_HIGH))
    else $error("watch wake mode wrong");
  a_select_no_sleep: assert property (
    sleep_exec && (mode_reg == ACT_HIGH || mode_reg == ACT_MED) && standby_select
      |=> !(mode_reg inside {SLEEP_HIGH, SLEEP_MED}))
    else $error("standby select entered sleep");
  a_sleep_ignored: assert property (
    sleep_exec && mode_reg == SLEEP_HIGH && !wake |=> mode_reg == SLEEP_HIGH)
    else $error("second sleep changed mode");
  a_med_divider: assert property (
    mode_reg inside {ACT_MED, SLEEP_MED}
      |-> cpu_clk_div == (DIV_16 << ctrl_one_reg[MDIV_LSB+:2]))
    else $error("medium divider wrong");
  a_exc_one_cycle: assert property (
    int_exc_start |=> !int_exc_start)
    else $error("exception start longer than one cycle");
  a_halt_in_sleep: assert property (
    mode_reg inside {SLEEP_HIGH, SLEEP_MED} |-> cpu_halt && !cpu_clk_from_watch)
    else $error("cpu not halted in sleep");

  c_sleep_high:  cover property (mode_reg == ACT_HIGH ##1 mode_reg == SLEEP_HIGH);
  c_sleep_wake:  cover property (mode_reg == SLEEP_MED ##1 int_exc_start);
  c_direct_sub:  cover property (mode_reg == ACT_MED ##1 mode_reg == SUBACTIVE);
  c_sub_back:    cover property (mode_reg == SUBACTIVE ##1 mode_reg == ACT_HIGH);
  c_sub_sleep:   cover property (mode_reg == SUBSLEEP ##1 mode_reg == SUBACTIVE);

endmodule // power_mode_ctrl
`default_nettype wire

// File: power_mode_pkg.sv
// Function
// - direct flag clear: active sleep goes standby/watch/sleep, subactive goes watch/subsleep
// - direct flag set, high-speed, standby 0, medium 1, low 0: go medium-speed
// - direct flag set, medium-speed, standby, medium, low all 0: go high-speed
// - direct flag set, either active mode, standby, watch bit, low all 1: subactive
// - direct flag set, subactive, standby 1, watch 1, low 0: active per medium flag
// - leaving standby, watch or sleep resumes active per medium flag; flag resets 0 (watch with low flag 1 goes to subactive instead)
// - subactive clock is watch clock /8 for 00, /4 for 01, /2 for 1x
// - subactive clock select writes are ignored while in subactive mode
// - active sleep with standby, low, medium, direct all 0 enters sleep high-speed
// - same with medium flag 1 enters sleep medium-speed, clocked by medium divider
// - sleep medium-speed entry may come half a state early; tolerate it
// - sleep ends on any enabled interrupt source or on the reset pin
// - interrupt wake starts exception handling and returns to same-speed active mode
// - sleep holds while the cpu interrupt mask is set or the source is disabled
// - asynchronous requests are synchronised, adding at most two clock periods
// - reset pin low during sleep ends sleep and holds the cpu in reset
// - standby select picks sleep modes (0) or standby/watch modes (1)
// - medium divider gives osc /16, /32, /64, /128 for codes 00..11; resets /128
package power_mode_pkg;

  localparam logic [4:0] CTRL_ONE_OFS    = 5'h00;
  localparam logic [4:0] CTRL_TWO_OFS    = 5'h04;
  localparam logic [4:0] TIMER_WATCH_OFS = 5'h08;
  localparam logic [4:0] INT_ENABLE_OFS  = 5'h0c;
  localparam logic [4:0] MODE_STATUS_OFS = 5'h10;

  localparam logic [7:0] CTRL_ONE_RST   = 8'h07;
  localparam logic [7:0] CTRL_TWO_RST   = 8'hf0;
  localparam logic [7:0] CTRL_ONE_FIXED = 8'h04;
  localparam logic [7:0] CTRL_TWO_FIXED = 8'he0;

  localparam int STBY_POS  = 7;
  localparam int LOW_SPEED_FLAG_POS  = 3;
  localparam int MDIV_LSB  = 0;
  localparam int DIRECT_TRANSFER_FLAG_POS  = 3;
  localparam int MEDIUM_SPEED_FLAG_POS  = 2;
  localparam int SA_LSB    = 0;
  localparam int TWATCH_POS = 0;

  // timer a, timer f, async counter, event pin, irq1, irq0, wakeup, serial, adc
  localparam int NUM_WAKE = 9;
  localparam logic [NUM_WAKE-1:0] INT_ENABLE_RST = 9'h000;

  localparam logic [7:0] DIV_NONE = 8'h00;
  localparam logic [7:0] DIV_1    = 8'h01;
  localparam logic [7:0] DIV_2    = 8'h02;
  localparam logic [7:0] DIV_4    = 8'h04;
  localparam logic [7:0] DIV_8    = 8'h08;
  localparam logic [7:0] DIV_16   = 8'h10;
  localparam logic [7:0] DIV_32   = 8'h20;
  localparam logic [7:0] DIV_64   = 8'h40;
  localparam logic [7:0] DIV_128  = 8'h80;

  localparam int CLK_PERIOD_NS = 4;
  localparam int SYNC_MAX_NS   = 8;
  localparam int SYNC_CYCLES   = SYNC_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [7:0] {
    ACT_HIGH   = 8'h01,
    ACT_MED    = 8'h02,
    SUBACTIVE  = 8'h04,
    SLEEP_HIGH = 8'h08,
    SLEEP_MED  = 8'h10,
    STANDBY    = 8'h20,
    WATCH      = 8'h40,
    SUBSLEEP   = 8'h80
  } mode_e;

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } av_req_s;

endpackage

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import power_mode_pkg::*;
  logic                core_clk;
  logic                sys_rst;
  av_req_s             bus_req;
  logic [31:0]         readdata;
  logic                waitrequest;
  logic                sleep_exec;
  logic                cpu_int_mask;
  logic [NUM_WAKE-1:0] wake_src_pins;
  logic                chip_reset_pin_n;
  mode_e               mode_state;
  logic                cpu_halt;
  logic                int_exc_start;
  logic                cpu_reset_hold;
  logic [7:0]          cpu_clk_div;
  logic                cpu_clk_from_watch;
  logic [31:0]         cur;
  logic [31:0]         prev_st;
  logic [31:0]         exp_rd[$];
  logic [31:0]         exp_st[$];
  logic [1:0]          sv;
  logic                watching;
  logic [3:0]          be_sel;
  int                  n_fail;
  int                  checks_done;

  power_mode_ctrl dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .readdata(readdata), .waitrequest(waitrequest), .sleep_exec(sleep_exec),
    .cpu_int_mask(cpu_int_mask), .wake_src_pins(wake_src_pins),
    .chip_reset_pin_n(chip_reset_pin_n), .mode_state(mode_state),
    .cpu_halt(cpu_halt), .int_exc_start(int_exc_start),
    .cpu_reset_hold(cpu_reset_hold), .cpu_clk_div(cpu_clk_div),
    .cpu_clk_from_watch(cpu_clk_from_watch)
  );
  cpu_wake_model cpu_u (
    .core_clk(core_clk), .sleep_exec(sleep_exec),
    .cpu_int_mask(cpu_int_mask), .wake_src_pins(wake_src_pins)
  );

  assign cur = {13'h0, mode_state, cpu_halt, int_exc_start, cpu_clk_from_watch, cpu_clk_div};
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] st(input mode_e m, input logic x, input logic [7:0] d);
    return {13'h0, m, !(m inside {ACT_HIGH, ACT_MED, SUBACTIVE}), x,
            m inside {SUBACTIVE, SUBSLEEP}, d};
  endfunction
  function automatic logic [7:0] sadiv(input logic [1:0] s);
    return s[1] ? DIV_2 : (s[0] ? DIV_4 : DIV_8);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic timeout_out();
    n_fail++;
    $display("timeout at %0t", $time);
    print_verdict();
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic [4:0] a, input logic r, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    bus_req.address    <= a;
    bus_req.read       <= r;
    bus_req.write      <= !r;
    bus_req.writedata  <= d | ($urandom & 32'hfffffe00);
    bus_req.byteenable <= be_sel;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    bus_req.read  <= 1'b0;
    bus_req.write <= 1'b0;
    if (waitrequest !== 1'b0) timeout_out();
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(a, 1'b0, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(a, 1'b1, 32'h0);
  endtask
  task automatic cfg(input logic sb, lo, input logic [1:0] ma, input logic dt, ms,
                     input logic [1:0] sa, input logic tw);
    wr(CTRL_ONE_OFS, {24'h0, sb, 3'b000, lo, 1'b1, ma});
    wr(CTRL_TWO_OFS, {24'h0, 4'hf, dt, ms, sa});
    wr(TIMER_WATCH_OFS, {31'h0, tw});
  endtask
  // bounded: the monitor must have taken every note in time
  task automatic wait_q(input int bound);
    int n;
    n = 0;
    while (exp_st.size() > 0 && n < bound) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (exp_st.size() > 0) timeout_out();
  endtask
  task automatic wait_hold();
    int n;
    n = 0;
    while (cpu_reset_hold !== 1'b0 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (cpu_reset_hold !== 1'b0) timeout_out();
  endtask
  task automatic jump(input mode_e m, input logic [7:0] d);
    exp_st.push_back(st(m, 1'b0, d));
    cpu_u.sleep_instr(1);
    wait_q(2);
  endtask
  // other pins raised at random stay disabled, so only src may wake
  task automatic nap_wake(input int src, input mode_e sl, input mode_e ac, input logic [7:0] d);
    logic [NUM_WAKE-1:0] one;
    one = NUM_WAKE'(1) << src;
    wr(INT_ENABLE_OFS, 32'(one));
    jump(sl, (sl inside {STANDBY, WATCH}) ? DIV_NONE : d);
    exp_st.push_back(st(ac, 1'b1, d));
    cpu_u.set_pins(one | NUM_WAKE'($urandom));
    wait_q(4);
    cpu_u.set_pins('0);
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    if (bus_req.read && waitrequest === 1'b0 && exp_rd.size() > 0)
      check(readdata, exp_rd.pop_front());
    if (watching && (cur[18:11] !== prev_st[18:11] || cur[7:0] !== prev_st[7:0])) begin
      if (exp_st.size() > 0) check(cur, exp_st.pop_front());
      else check(cur, prev_st);
    end
    prev_st = cur;
  end

  initial begin
    bus_req          = '0;
    sys_rst          = 1'b1;
    chip_reset_pin_n = 1'b1;
    n_fail           = 0;
    checks_done      = 0;
    watching         = 1'b0;
    void'($urandom(96013));
    be_sel           = 4'($urandom) | 4'h1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    wait_hold();
    watching = 1'b1;
    check({24'h0, cpu_clk_div}, 32'h1);
    rd(CTRL_ONE_OFS, 32'h07);
    rd(CTRL_TWO_OFS, 32'hf0);
    rd(MODE_STATUS_OFS, 32'h01);
    rd(5'h14, 32'h0);
    // low byte lane off: the write must not land
    be_sel = 4'he;
    wr(CTRL_ONE_OFS, 32'h0);
    rd(CTRL_ONE_OFS, 32'h07);
    be_sel = 4'($urandom) | 4'h1;
    wr(CTRL_ONE_OFS, 32'h0);
    rd(CTRL_ONE_OFS, 32'h04);
    wr(CTRL_TWO_OFS, 32'h0);
    rd(CTRL_TWO_OFS, 32'he0);
    $display("test registers done");
    for (int i = 0; i < NUM_WAKE; i++) begin
      cfg(1'b0, 1'b0, 2'(i >> 1), 1'b0, i[0], 2'b00, 1'b0);
      if (i[0]) begin
        nap_wake(i, SLEEP_MED, ACT_MED, DIV_16 << (i >> 1));
        cfg(1'b0, 1'b0, 2'(i >> 1), 1'b1, 1'b0, 2'b00, 1'b0);
        jump(ACT_HIGH, DIV_1);
      end else begin
        nap_wake(i, SLEEP_HIGH, ACT_HIGH, DIV_1);
      end
    end
    $display("test sleep and wake done");
    cfg(1'b0, 1'b0, 2'b10, 1'b1, 1'b1, 2'b00, 1'b0);
    jump(ACT_MED, DIV_64);
    for (int k = 0; k < 4; k++) begin
      sv = 2'(k);
      cfg(1'b1, 1'b1, 2'b10, 1'b1, 1'b0, sv, 1'b1);
      jump(SUBACTIVE, sadiv(sv));
      wr(CTRL_ONE_OFS, 32'h86);
      wr(CTRL_TWO_OFS, {24'h0, 5'h1f, sv[0], ~sv});
      rd(CTRL_TWO_OFS, {24'h0, 5'h1f, sv[0], sv});
      jump(sv[0] ? ACT_MED : ACT_HIGH, sv[0] ? DIV_64 : DIV_1);
    end
    $display("test direct transfer done");
    cfg(1'b1, 1'b0, 2'b10, 1'b0, 1'b0, 2'b00, 1'b0);
    nap_wake(5, STANDBY, ACT_HIGH, DIV_1);
    cfg(1'b1, 1'b0, 2'b10, 1'b0, 1'b1, 2'b00, 1'b1);
    nap_wake(5, WATCH, ACT_MED, DIV_64);
    $display("test standby and watch done");
    cfg(1'b1, 1'b1, 2'b10, 1'b0, 1'b0, 2'b01, 1'b1);
    nap_wake(6, WATCH, SUBACTIVE, DIV_4);
    wr(CTRL_ONE_OFS, 32'h06);
    nap_wake(7, SUBSLEEP, SUBACTIVE, DIV_4);
    wr(CTRL_ONE_OFS, 32'h86);
    wr(CTRL_TWO_OFS, 32'hf9);
    jump(ACT_HIGH, DIV_1);
    $display("test subactive sleep done");
    cfg(1'b0, 1'b0, 2'b10, 1'b0, 1'b0, 2'b00, 1'b0);
    wr(INT_ENABLE_OFS, 32'h001);
    cpu_u.set_mask(1'b1);
    jump(SLEEP_HIGH, DIV_1);
    cpu_u.set_pins(9'h1ff);
    repeat (8) @(posedge core_clk);
    cpu_u.set_pins(9'h1fe);
    repeat (4) @(posedge core_clk);
    cpu_u.set_mask(1'b0);
    repeat (8) @(posedge core_clk);
    exp_st.push_back(st(ACT_HIGH, 1'b1, DIV_1));
    cpu_u.set_pins(9'h1ff);
    wait_q(4);
    cpu_u.set_pins('0);
    $display("test mask done");
    exp_st.push_back(st(SLEEP_HIGH, 1'b0, DIV_1));
    cpu_u.sleep_instr(2);
    wait_q(2);
    exp_st.push_back(st(ACT_HIGH, 1'b0, DIV_1));
    @(posedge core_clk);
    chip_reset_pin_n <= 1'b0;
    wait_q(5);
    check({31'h0, cpu_reset_hold}, 32'h1);
    @(posedge core_clk);
    chip_reset_pin_n <= 1'b1;
    wait_hold();
    rd(CTRL_TWO_OFS, 32'hf0);
    $display("test reset pin done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire

// File: wake_sync.sv
`timescale 1ns/1ps
`default_nettype none
module wake_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule // wake_sync
`default_nettype wire
